//--- smsc_map.svh
// Constants for the switch monitor serial control core
`ifndef SMSC_MAP_SVH
`define SMSC_MAP_SVH
`define SMSC_FRAME_BITS     24
`define SMSC_CHAIN_BITS     48
`define SMSC_OP_HI          23
`define SMSC_OP_LO          16
`define SMSC_OP_SETTINGS    8'h01
`define SMSC_OP_WAKE_PROG   8'h02
`define SMSC_OP_WAKE_GND    8'h03
`define SMSC_OP_RESET       8'h7F
`define SMSC_RST_FLAG_BIT   22
`define SMSC_THERM_FLAG_BIT 23
`define SMSC_POL_RESET      8'hFF
`define SMSC_WPROG_RESET    8'hFF
`define SMSC_WGND_RESET     14'h3FFF
`define SMSC_NUM_PROG       8
`define SMSC_NUM_GND        14
`endif

//--- smsc_pkg.sv
// Types for the switch monitor serial control core
package smsc_pkg;
    typedef enum logic [0:0]
    {
        SMSC_NORMAL = 1'b0,
        SMSC_SLEEP  = 1'b1
    } smsc_mode_e;
endpackage

//--- smsc_core.sv
// Serial command interpreter and switch status core
// Overview of operation
// - A frame is twenty-four bits under select
// - Every reply carries switches, reset, thermal flags
// - Select fall captures switch states for reply
// - Status shifts out while command shifts in
// - Forty-eight clock chained frames pass status through, but their commands are refused
// - Losing logic supply never changes the mode
// - Without logic supply, ignore select and interrupt pin wakes
// - Reset applies documented default settings
// - Reset flag set, cleared on select rise
// - Listed wake events enter Normal mode
// - Commands accepted only Normal with logic supply
// - Interrupt released on select rise unless new change
// - Settings command picks battery or ground sense
// - Closed programmable input reads as one
// - Enable bit gates interrupt and wake per input
// - Wake opcodes two and three select input groups
// - Settings rewritable any time in Normal mode
// - Programmable input sense follows polarity setting
// - Ground inputs read closed when comparator low
// - Thermal flag tracked during Normal mode
// - Sample on serial clock fall, shift on rise, MSB first
// - Command acts only on select rise
// - Enabled change in Normal drives interrupt low
`timescale 1ns/1ps
`include "smsc_map.svh"
module smsc_core
(
    // System
    input  wire logic        CLK,
    input  wire logic        RST,
    // Serial link, clocked by the host
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        SI,
    output logic             SO,
    output logic             SO_OE,
    // Comparator levels, high means above threshold
    input  wire logic [7:0]  PROG_ABOVE,
    input  wire logic [13:0] GND_ABOVE,
    // Supplies and status
    input  wire logic        LOGIC_SUPPLY_OK,
    input  wire logic        THERMAL_WARN,
    input  wire logic        TIMER_EXPIRED,
    // Wake and interrupt pins, open drain
    input  wire logic        WAKE_N_IN,
    output logic             WAKE_N_OUT,
    output logic             WAKE_N_OE,
    input  wire logic        INT_N_IN,
    output logic             INT_N_OUT,
    output logic             INT_N_OE,
    // Settings visible to analog side
    output logic [7:0]       POLARITY,
    output logic [7:0]       WAKE_EN_PROG,
    output logic [13:0]      WAKE_EN_GND,
    output logic             SLEEP_MODE
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shift register on SCLK, reset while select high

    logic [23:0] shift_in;
    logic [23:0] shift_out;
    logic [23:0] status_snap;
    logic        first_rise;

    // Unknown reset-free shift register is avoided by async clear on select high
    always_ff @(negedge SCLK or posedge CS_N)
    begin
        if (CS_N)
            shift_in <= 24'h00_0000;
        else
            shift_in <= {shift_in[22:0], SI};
    end

    // Status word is presented MSB first and advanced on rising edges
    always_ff @(posedge SCLK or posedge CS_N)
    begin
        if (CS_N)
        begin
            first_rise <= 1'b1;
            shift_out  <= 24'h00_0000;
        end
        else if (first_rise)
        begin
            first_rise <= 1'b0;
            shift_out  <= {status_snap[22:0], SI};
        end
        else
        begin
            shift_out  <= {shift_out[22:0], SI};
        end
    end

    assign SO    = (first_rise ? status_snap[23] : shift_out[23]) & LOGIC_SUPPLY_OK;
    assign SO_OE = ~CS_N & LOGIC_SUPPLY_OK;

    ////////////////////////////////////////////////////////////////////////////
    // Select, wake and interrupt synchronisers into CLK

    logic [2:0] cs_sync;
    logic       cs_low;
    logic       cs_fall;
    logic       cs_rise;
    logic [2:0] wake_sync;
    logic       wake_lvl;
    logic [2:0] int_sync;
    logic       int_lvl;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cs_sync   <= 3'h7;
            wake_sync <= 3'h7;
            int_sync  <= 3'h7;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], CS_N};
            wake_sync <= {wake_sync[1:0], WAKE_N_IN};
            int_sync  <= {int_sync[1:0], INT_N_IN};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cs_low   <= 1'b0;
            wake_lvl <= 1'b1;
            int_lvl  <= 1'b1;
        end
        else
        begin
            if (cs_sync[1] == cs_sync[2])
                cs_low <= ~cs_sync[2];
            if (wake_sync[1] == wake_sync[2])
                wake_lvl <= wake_sync[2];
            if (int_sync[1] == int_sync[2])
                int_lvl <= int_sync[2];
        end
    end

    logic cs_low_d;
    logic wake_d;
    logic int_d;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cs_low_d <= 1'b0;
            wake_d   <= 1'b1;
            int_d    <= 1'b1;
        end
        else
        begin
            cs_low_d <= cs_low;
            wake_d   <= wake_lvl;
            int_d    <= int_lvl;
        end
    end

    assign cs_fall = cs_low & ~cs_low_d;
    assign cs_rise = ~cs_low & cs_low_d;

    ////////////////////////////////////////////////////////////////////////////
    // Switch states

    logic [7:0]  prog_closed;
    logic [13:0] gnd_closed;
    logic [21:0] sw_now;
    logic [21:0] sw_prev;
    logic [21:0] sw_change;

    // Comparator outputs are treated as already settled analog levels
    assign prog_closed = ~(PROG_ABOVE ^ POLARITY);
    assign gnd_closed  = ~GND_ABOVE;
    assign sw_now      = {gnd_closed, prog_closed};

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            sw_prev <= 22'h00_0000;
        else
            sw_prev <= sw_now;
    end

    assign sw_change = (sw_now ^ sw_prev) & {WAKE_EN_GND, WAKE_EN_PROG};

    ////////////////////////////////////////////////////////////////////////////
    // Status snapshot, held stable for the link while select is low

    logic reset_flag;
    logic therm_flag;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            therm_flag <= 1'b0;
        else if (!SLEEP_MODE)
            therm_flag <= THERMAL_WARN;
    end

    // Snapshot is taken while select is still high, then frozen on fall
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            status_snap <= 24'h00_0000;
        else if (!cs_low)
            status_snap <= {therm_flag, reset_flag, sw_now};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command word transfer: level handshake on select, stable while high

    logic [23:0] cmd_word;
    logic        cmd_count_ok;
    logic [5:0]  bit_count;
    logic [29:0] word_d1;
    logic [29:0] word_d2;

    always_ff @(negedge SCLK or posedge CS_N)
    begin
        if (CS_N)
            bit_count <= 6'h00;
        else if (bit_count != 6'h3F)
            bit_count <= bit_count + 6'h01;
    end

    // Select high clears the link word at once, so copy it two cycles late
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            word_d1      <= 30'h0000_0000;
            word_d2      <= 30'h0000_0000;
            cmd_word     <= 24'h00_0000;
            cmd_count_ok <= 1'b0;
        end
        else
        begin
            word_d1 <= {bit_count, shift_in};
            word_d2 <= word_d1;
            if (!cs_sync[1])
            begin
                cmd_word     <= word_d2[23:0];
                cmd_count_ok <= (word_d2[29:24] == 6'(`SMSC_FRAME_BITS));
            end
        end
    end

    logic [7:0] opcode;
    logic       cmd_ok;

    assign opcode = cmd_word[`SMSC_OP_HI:`SMSC_OP_LO];
    assign cmd_ok = cs_rise & cmd_count_ok & !SLEEP_MODE & LOGIC_SUPPLY_OK;

    ////////////////////////////////////////////////////////////////////////////
    // Settings registers

    logic soft_reset;

    assign soft_reset = cmd_ok & (opcode == `SMSC_OP_RESET);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            POLARITY     <= `SMSC_POL_RESET;
            WAKE_EN_PROG <= `SMSC_WPROG_RESET;
            WAKE_EN_GND  <= `SMSC_WGND_RESET;
        end
        else if (soft_reset)
        begin
            POLARITY     <= `SMSC_POL_RESET;
            WAKE_EN_PROG <= `SMSC_WPROG_RESET;
            WAKE_EN_GND  <= `SMSC_WGND_RESET;
        end
        else if (cmd_ok)
        begin
            // Only the field bits are written; upper bits are ignored
            case (opcode)
                `SMSC_OP_SETTINGS:  POLARITY     <= cmd_word[7:0];
                `SMSC_OP_WAKE_PROG: WAKE_EN_PROG <= cmd_word[7:0];
                `SMSC_OP_WAKE_GND:  WAKE_EN_GND  <= cmd_word[13:0];
                default:            POLARITY     <= POLARITY;
            endcase
        end
    end

    // Set wins over clear: a new reset beats the clearing select edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            reset_flag <= 1'b1;
        else if (soft_reset)
            reset_flag <= 1'b1;
        else if (cs_rise)
            reset_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode control

    smsc_pkg::smsc_mode_e mode;
    logic                 wake_event;
    logic                 sleep_req;

    // Pin wakes on select or interrupt need the logic supply
    assign wake_event = (|sw_change) | (wake_d & ~wake_lvl) | TIMER_EXPIRED
                      | (LOGIC_SUPPLY_OK & cs_fall)
                      | (LOGIC_SUPPLY_OK & int_d & ~int_lvl & wake_lvl);

    // Sleep entry is outside this block; no sleep command is decoded
    assign sleep_req = 1'b0;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            mode <= smsc_pkg::SMSC_NORMAL;
        else
        begin
            case (mode)
                smsc_pkg::SMSC_NORMAL: if (sleep_req) mode <= smsc_pkg::SMSC_SLEEP;
                smsc_pkg::SMSC_SLEEP:  if (wake_event) mode <= smsc_pkg::SMSC_NORMAL;
                default:               mode <= smsc_pkg::SMSC_NORMAL;
            endcase
        end
    end

    assign SLEEP_MODE = (mode == smsc_pkg::SMSC_SLEEP);
    assign WAKE_N_OUT = 1'b0;
    assign WAKE_N_OE  = ~SLEEP_MODE;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt

    logic int_pend;
    logic chg_in_frame;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            chg_in_frame <= 1'b0;
        else if (cs_fall)
            chg_in_frame <= 1'b0;
        else if (cs_low && (|sw_change))
            chg_in_frame <= 1'b1;
    end

    // A change in the release cycle keeps the line asserted
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            int_pend <= 1'b0;
        else if (!SLEEP_MODE && (|sw_change))
            int_pend <= 1'b1;
        else if (cs_rise && !chg_in_frame)
            int_pend <= 1'b0;
    end

    assign INT_N_OUT = 1'b0;
    assign INT_N_OE  = int_pend;

endmodule

//--- smsc_core_properties.sv
// Port assertions for the serial control core
`timescale 1ns/1ps
module smsc_core_props
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Watched ports
    input wire logic        CS_N,
    input wire logic        SO_OE,
    input wire logic [7:0]  PROG_ABOVE,
    input wire logic [13:0] GND_ABOVE,
    input wire logic        LOGIC_SUPPLY_OK,
    input wire logic        INT_N_OE,
    input wire logic [7:0]  POLARITY,
    input wire logic [7:0]  WAKE_EN_PROG,
    input wire logic [13:0] WAKE_EN_GND,
    input wire logic        SLEEP_MODE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    logic [21:0] prev;
    logic        chg;
    wire         evt = |(({GND_ABOVE, PROG_ABOVE} ^ prev) & {WAKE_EN_GND, WAKE_EN_PROG});
    ////////////////////////////////////////
    // Enabled change, and whether one fell under select
    always_ff @(posedge CLK)
        prev <= {GND_ABOVE, PROG_ABOVE};
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            chg <= 1'b0;
        else if ($fell(CS_N))
            chg <= 1'b0;
        else if (evt && !CS_N)
            chg <= 1'b1;
    ////////////////////////////////////////
    sequence s_frame_end;
        $rose(CS_N) && LOGIC_SUPPLY_OK;
    endsequence
    sequence s_supply_gone;
        (!LOGIC_SUPPLY_OK) [*8];
    endsequence
    chk_so_drive: assert property (SO_OE == (!CS_N && LOGIC_SUPPLY_OK))
        else $error("SO enable disagrees with select and supply");
    chk_int_release: assert property (s_frame_end ##0 !chg |-> ##[1:8] !INT_N_OE)
        else $error("interrupt kept after select rise");
    chk_int_hold: assert property (s_frame_end ##0 chg |=> INT_N_OE [*8])
        else $error("interrupt dropped despite change under select");
    chk_int_raise: assert property (evt && CS_N && !SLEEP_MODE |-> ##[1:8] INT_N_OE)
        else $error("enabled change raised no interrupt");
    chk_cfg_hold: assert property (!CS_N && !$past(CS_N) |->
        $stable({POLARITY, WAKE_EN_PROG, WAKE_EN_GND}))
        else $error("settings moved during a frame");
    chk_supply_off: assert property (s_supply_gone |->
        $stable({POLARITY, WAKE_EN_PROG, WAKE_EN_GND}))
        else $error("settings moved without logic supply");
    chk_mode_kept: assert property ($fell(LOGIC_SUPPLY_OK) |=> $stable(SLEEP_MODE) [*4])
        else $error("mode changed on supply loss");
    chk_reset_dflt: assert property ($fell(RST) |-> POLARITY == 8'hff &&
        WAKE_EN_PROG == 8'hff && WAKE_EN_GND == 14'h3fff && !SLEEP_MODE)
        else $error("reset defaults wrong");
endmodule

//--- smsc_host.sv
// Host model: serial master for frames of up to 24 bits
`timescale 1ns/1ps
module smsc_host
(
    // Serial link
    output logic      SCLK,
    output logic      CS_N,
    output logic      SI,
    input  wire logic SO
);
    logic [23:0] rsp;
    event        done;
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI   = 1'b0;
    end
    ////////////////////////////////////////
    // Clock idles low, so select only moves with it low; SI inverts after so no stale bit lingers
    task automatic frame(input int n, input logic [23:0] c, input bit rep);
        CS_N = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--)
        begin
            #1 SI = c[i];
            rsp[i] = SO;
            #15 SCLK = 1'b1;
            #16 SCLK = 1'b0;
        end
        #20 CS_N = 1'b1;
        SI = ~SI;
        #40;
        if (rep)
            -> done;
    endtask
endmodule

//--- smsc_core_tb_top.sv
// Testbench top for the serial control core
`timescale 1ns/1ps
`include "smsc_map.svh"
module smsc_core_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sup = 1'b1;
    logic        therm = 1'b0;
    logic        rflag = 1'b1;
    logic [7:0]  pa = 8'h00;
    logic [7:0]  pol = 8'hff;
    logic [7:0]  wp = 8'hff;
    logic [13:0] ga = 14'h0000;
    logic [13:0] wg = 14'h3fff;
    logic [21:0] old;
    logic [31:0] r = 32'h0000_09f3;
    logic [23:0] exp_q[$];
    int          fails = 0;
    int          check_count = 0;
    wire         sclk, cs_n, si, so, so_oe, wk_out, wk_oe, in_out, in_oe, slp;
    wire [7:0]   pol_q, wep_q;
    wire [13:0]  weg_q;
    always #2.5 clk = ~clk;
    smsc_core i_dut
    (
        .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
        .PROG_ABOVE(pa), .GND_ABOVE(ga), .LOGIC_SUPPLY_OK(sup), .THERMAL_WARN(therm),
        .TIMER_EXPIRED(1'b0), .WAKE_N_IN(wk_oe ? wk_out : 1'b1), .WAKE_N_OUT(wk_out),
        .WAKE_N_OE(wk_oe), .INT_N_IN(in_oe ? in_out : 1'b1), .INT_N_OUT(in_out),
        .INT_N_OE(in_oe), .POLARITY(pol_q), .WAKE_EN_PROG(wep_q), .WAKE_EN_GND(weg_q),
        .SLEEP_MODE(slp)
    );
    smsc_host i_host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] want);
        check_count++;
        if (got !== want)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    task automatic send(input int n, input logic [23:0] c, input bit rep);
        if (rep)
            exp_q.push_back({therm, rflag, ~ga, ~(pa ^ pol)});
        i_host.frame(n, c, rep);
        rflag = 1'b0;
    endtask
    task automatic cfg();
        check(24'(pol_q), 24'(pol));
        check(24'(wep_q), 24'(wp));
        check(24'(weg_q), 24'(wg));
        check(24'(slp), 24'(smsc_pkg::SMSC_NORMAL));
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] d);
        send(24, {op, d}, 1'b1);
        case (op)
            `SMSC_OP_SETTINGS:  pol = d[7:0];
            `SMSC_OP_WAKE_PROG: wp = d[7:0];
            `SMSC_OP_WAKE_GND:  wg = d[13:0];
            `SMSC_OP_RESET:     {pol, wp, wg, rflag} = {8'hff, 8'hff, 14'h3fff, 1'b1};
            default:            ;
        endcase
        cfg();
    endtask
    // Interrupt level is latched, so a late look still sees it
    task automatic wint(input logic v);
        repeat (10) @(posedge clk);
        for (int i = 0; i < 40 && in_oe !== v; i++)
            @(posedge clk);
        #1 check(24'(in_oe), 24'(v));
        if (in_oe !== v)
            print_verdict();
    endtask
    ////////////////////////////////////////
    initial
        forever
        begin
            @(i_host.done);
            check(i_host.rsp, exp_q.pop_front());
        end
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 cfg();
        send(24, 24'h00_0000, 1'b1);
        send(24, 24'h00_0000, 1'b1);
        $display("test reset flag done");
        for (int k = 0; k < 4; k++)
        begin
            old = {ga, pa};
            r = lfsr(r);
            @(posedge clk) #1 {therm, ga, pa} = r[22:0];
            wint(|((old ^ {ga, pa}) & {wg, wp}));
            r = lfsr(r);
            cmd(`SMSC_OP_SETTINGS, r[15:0]);
            cmd(`SMSC_OP_WAKE_PROG, r[31:16]);
            r = lfsr(r);
            cmd(`SMSC_OP_WAKE_GND, r[15:0]);
        end
        $display("test commands done");
        send(23, {`SMSC_OP_SETTINGS, 16'h0000}, 1'b0);
        cfg();
        cmd(8'h05, 16'h0000);
        @(posedge clk) #1 sup = 1'b0;
        send(24, {`SMSC_OP_SETTINGS, 16'h0000}, 1'b0);
        @(posedge clk) #1 sup = 1'b1;
        cfg();
        $display("test refusals done");
        cmd(`SMSC_OP_WAKE_PROG, 16'h00ff);
        cmd(`SMSC_OP_WAKE_GND, 16'h3fff);
        fork
            send(24, 24'h00_0000, 1'b1);
            begin
                #300;
                @(posedge clk) #1 ga[0] = ~ga[0];
            end
        join
        wint(1'b1);
        send(24, 24'h00_0000, 1'b1);
        wint(1'b0);
        cmd(`SMSC_OP_RESET, 16'h0000);
        send(24, 24'h00_0000, 1'b1);
        $display("test interrupt and reset done");
        repeat (2) @(posedge clk);
        check(24'(exp_q.size()), 24'h00_0000);
        print_verdict();
    end
endmodule
bind smsc_core smsc_core_props i_chk
(
    .CLK(CLK), .RST(RST), .CS_N(CS_N), .SO_OE(SO_OE), .PROG_ABOVE(PROG_ABOVE),
    .GND_ABOVE(GND_ABOVE), .LOGIC_SUPPLY_OK(LOGIC_SUPPLY_OK), .INT_N_OE(INT_N_OE),
    .POLARITY(POLARITY), .WAKE_EN_PROG(WAKE_EN_PROG), .WAKE_EN_GND(WAKE_EN_GND),
    .SLEEP_MODE(SLEEP_MODE)
);
